// [rtl/mhcc_motion_host_control.sv]
`timescale 1ns/10ps
// Operation
// - Opcodes 64..71 are user functions, answered with status 100.
// - Position-reached request gives an immediate reply and a later one.
// - Position-reached request only from host in direct mode, never stored.
// - Type 0 arms for the next move only, type 1 for every move.
// - Immediate reply: status 100, command 138, mask in byte 0.
// - On reaching target: status 128, command 138, mask in byte 0.
// - Control commands run only from host and are never stored.
// - Opcode 128 halts the running program.
// - Opcode 129 resumes (type 0) or starts at value (type 1).
// - Opcode 130 executes one instruction then stays halted.
// - Opcode 131 stops and clears counter, stack, accumulator, index, flags.
// - Opcode 132 enters download at value; others get stored.
// - Opcode 133 leaves download mode.
// - Opcode 134 returns the addressed program word, special format.
// - Opcode 135 returns status chosen by type 0..3.
// - Opcode 136 returns version as string (0) or binary (1).
// - Opcode 137 with 1234 restores defaults and sends no reply.
// - Opcode 255 with 1234 restarts the processor.
module mhcc_motion_host_control import mhcc_pkg::*; (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CMD_TYPE,
	input wire logic [7:0] CMD_BANK,
	input wire logic [31:0] CMD_VALUE,
	input wire logic [31:0] UF_RESULT,
	input wire logic [31:0] ACCUM,
	input wire logic [31:0] INDEX_REG,
	input wire logic WAIT_FLAG,
	input wire logic MOVE_START,
	input wire logic MOVE_DONE,
	input wire logic EXEC_READY,
	output logic RPL_VALID,
	output logic [7:0] RPL_STATUS,
	output logic [7:0] RPL_COMMAND,
	output logic [31:0] RPL_VALUE,
	output logic EXEC_VALID,
	output logic [7:0] EXEC_OPCODE,
	output logic [7:0] EXEC_TYPE,
	output logic [7:0] EXEC_BANK,
	output logic [31:0] EXEC_VALUE,
	output logic EXEC_FROM_PROG,
	output logic UF_STROBE,
	output logic CTX_CLEAR,
	output logic FACTORY_RESTORE,
	output logic CPU_RESTART,
	output logic DOWNLOAD_MODE
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic [55:0] prog_mem [PM_DEPTH];
	logic [55:0] rd_word;
	logic [55:0] fetch_word;
	logic [PM_AW-1:0] dl_addr;
	logic [PM_AW-1:0] pc;
	mhcc_seq_e seq_state;
	logic fetch_req;
	logic grant;
	logic exec_free;
	logic [7:0] mode_code;
	logic armed;
	logic arm_every;
	logic pending;
	logic evt_flag;
	logic evt_taken;
	logic [7:0] evt_mask;
	logic imm_valid;
	logic [7:0] imm_status;
	logic [7:0] imm_cmd;
	logic [31:0] imm_value;
	logic do_store;
	logic do_fwd;
	logic do_uf;
	logic do_arm;
	logic do_halt;
	logic do_run;
	logic do_run_at;
	logic do_step;
	logic do_clear;
	logic do_dl_enter;
	logic do_dl_exit;
	logic do_factory;
	logic do_restart;

	assign rd_word = prog_mem[CMD_VALUE[PM_AW-1:0]];
	assign fetch_word = prog_mem[pc];
	assign exec_free = !EXEC_VALID || EXEC_READY;
	assign grant = fetch_req && exec_free && !do_fwd;

	always_comb begin
		unique case (seq_state)
			SEQ_HALTED: mode_code = MODE_HALTED;
			SEQ_RUNNING: mode_code = MODE_RUNNING;
			SEQ_STEPPING: mode_code = MODE_STEPPING;
		endcase
		if (DOWNLOAD_MODE) begin
			mode_code = MODE_DOWNLOAD;
		end
	end

	// ************************************************************
	// Command decode
	// ************************************************************
	always_comb begin
		imm_valid = CMD_VALID;
		imm_status = ST_OK;
		imm_cmd = CMD_OPCODE;
		imm_value = 32'h00000000;
		do_store = 1'b0;
		do_fwd = 1'b0;
		do_uf = 1'b0;
		do_arm = 1'b0;
		do_halt = 1'b0;
		do_run = 1'b0;
		do_run_at = 1'b0;
		do_step = 1'b0;
		do_clear = 1'b0;
		do_dl_enter = 1'b0;
		do_dl_exit = 1'b0;
		do_factory = 1'b0;
		do_restart = 1'b0;
		if (CMD_VALID && mhcc_is_control(CMD_OPCODE)) begin
			// Control commands act even in download mode
			case (CMD_OPCODE)
				OP_STOP: do_halt = 1'b1;
				OP_RUN: begin
					if (CMD_TYPE == 8'h00) begin
						do_run = 1'b1;
					end else if (CMD_TYPE == 8'h01) begin
						do_run_at = 1'b1;
					end else begin
						imm_status = ST_BAD_TYPE;
					end
				end
				OP_STEP: do_step = 1'b1;
				OP_RESET: do_clear = 1'b1;
				OP_DL_ENTER: do_dl_enter = 1'b1;
				OP_DL_EXIT: do_dl_exit = 1'b1;
				OP_READ_MEM: begin
					// Bank byte of the stored word is not returned
					imm_status = rd_word[55:48];
					imm_cmd = rd_word[47:40];
					imm_value = rd_word[31:0];
				end
				OP_STATUS: begin
					case (CMD_TYPE)
						8'h00: imm_value = {mode_code, 7'h00, WAIT_FLAG, 8'h00, dl_addr};
						8'h01: imm_value = {mode_code, 7'h00, WAIT_FLAG, 8'h00, pc};
						8'h02: imm_value = ACCUM;
						8'h03: imm_value = INDEX_REG;
						default: imm_status = ST_BAD_TYPE;
					endcase
				end
				OP_VERSION: begin
					case (CMD_TYPE)
						8'h00: imm_value = VERSION_STR;
						8'h01: imm_value = VERSION_BIN;
						default: imm_status = ST_BAD_TYPE;
					endcase
				end
				OP_FACTORY: begin
					if (CMD_VALUE == MAGIC_VALUE) begin
						do_factory = 1'b1;
						imm_valid = 1'b0;
					end else begin
						imm_status = ST_BAD_VALUE;
					end
				end
				OP_RESTART: begin
					// Reply leaves with the pulse; it may be lost downstream
					if (CMD_VALUE == MAGIC_VALUE) begin
						do_restart = 1'b1;
					end else begin
						imm_status = ST_BAD_VALUE;
					end
				end
				default: imm_status = ST_BAD_CMD;
			endcase
		end else if (CMD_VALID && CMD_OPCODE == OP_POS_EVT) begin
			if (DOWNLOAD_MODE) begin
				imm_status = ST_BAD_CMD;
			end else if (CMD_TYPE > 8'h01) begin
				imm_status = ST_BAD_TYPE;
			end else begin
				do_arm = 1'b1;
				imm_value = {24'h000000, CMD_VALUE[7:0]};
			end
		end else if (CMD_VALID && DOWNLOAD_MODE) begin
			do_store = 1'b1;
		end else if (CMD_VALID && CMD_OPCODE >= OP_UF_FIRST && CMD_OPCODE <= OP_UF_LAST) begin
			do_uf = 1'b1;
			imm_value = UF_RESULT;
		end else if (CMD_VALID && !exec_free) begin
			imm_status = ST_BUSY;
		end else if (CMD_VALID) begin
			// Executor answers forwarded commands itself
			do_fwd = 1'b1;
			imm_valid = 1'b0;
		end
	end

	// ************************************************************
	// Program memory and download
	// ************************************************************
	always_ff @(posedge CLOCK) begin
		if (do_store) begin
			prog_mem[dl_addr] <= {CMD_OPCODE, CMD_TYPE, CMD_BANK, CMD_VALUE};
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			DOWNLOAD_MODE <= 1'b0;
		end else if (do_dl_enter) begin
			DOWNLOAD_MODE <= 1'b1;
		end else if (do_dl_exit) begin
			DOWNLOAD_MODE <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			dl_addr <= PC_RESET;
		end else if (do_dl_enter) begin
			dl_addr <= CMD_VALUE[PM_AW-1:0];
		end else if (do_store) begin
			dl_addr <= dl_addr + 8'h01;
		end
	end

	// ************************************************************
	// Sequencer and executor slot
	// ************************************************************
	mhcc_prog_seq u_seq (
		.clock(CLOCK),
		.rst_b(RST_B),
		.halt(do_halt),
		.run(do_run),
		.run_at(do_run_at),
		.start_addr(CMD_VALUE[PM_AW-1:0]),
		.step(do_step),
		.clear(do_clear),
		.download(DOWNLOAD_MODE),
		.grant(grant),
		.pc(pc),
		.state(seq_state),
		.fetch_req(fetch_req)
	);

	// Host commands take the slot ahead of program fetches
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			EXEC_VALID <= 1'b0;
			EXEC_OPCODE <= 8'h00;
			EXEC_TYPE <= 8'h00;
			EXEC_BANK <= 8'h00;
			EXEC_VALUE <= 32'h00000000;
			EXEC_FROM_PROG <= 1'b0;
		end else if (do_fwd) begin
			EXEC_VALID <= 1'b1;
			EXEC_OPCODE <= CMD_OPCODE;
			EXEC_TYPE <= CMD_TYPE;
			EXEC_BANK <= CMD_BANK;
			EXEC_VALUE <= CMD_VALUE;
			EXEC_FROM_PROG <= 1'b0;
		end else if (grant) begin
			EXEC_VALID <= 1'b1;
			EXEC_OPCODE <= fetch_word[55:48];
			EXEC_TYPE <= fetch_word[47:40];
			EXEC_BANK <= fetch_word[39:32];
			EXEC_VALUE <= fetch_word[31:0];
			EXEC_FROM_PROG <= 1'b1;
		end else if (EXEC_READY) begin
			EXEC_VALID <= 1'b0;
		end
	end

	// ************************************************************
	// Strobes
	// ************************************************************
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			UF_STROBE <= 1'b0;
			CTX_CLEAR <= 1'b0;
			FACTORY_RESTORE <= 1'b0;
			CPU_RESTART <= 1'b0;
		end else begin
			UF_STROBE <= do_uf;
			CTX_CLEAR <= do_clear;
			FACTORY_RESTORE <= do_factory;
			CPU_RESTART <= do_restart;
		end
	end

	// ************************************************************
	// Position-reached event
	// ************************************************************
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			armed <= 1'b0;
			arm_every <= 1'b0;
			evt_mask <= 8'h00;
		end else if (do_arm) begin
			armed <= 1'b1;
			arm_every <= CMD_TYPE[0];
			evt_mask <= CMD_VALUE[7:0];
		end else if (MOVE_START && !arm_every) begin
			armed <= 1'b0;
		end
	end

	// A start while armed in the same cycle as a finish keeps the event pending
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pending <= 1'b0;
		end else if (MOVE_START && armed) begin
			pending <= 1'b1;
		end else if (MOVE_DONE) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			evt_flag <= 1'b0;
		end else if (MOVE_DONE && pending) begin
			evt_flag <= 1'b1;
		end else if (evt_taken) begin
			evt_flag <= 1'b0;
		end
	end

	mhcc_reply_out u_reply (
		.clock(CLOCK),
		.rst_b(RST_B),
		.imm_valid(imm_valid),
		.imm_status(imm_status),
		.imm_cmd(imm_cmd),
		.imm_value(imm_value),
		.evt_req(evt_flag),
		.evt_mask(evt_mask),
		.evt_taken(evt_taken),
		.rpl_valid(RPL_VALID),
		.rpl_status(RPL_STATUS),
		.rpl_cmd(RPL_COMMAND),
		.rpl_value(RPL_VALUE)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	sequence s_evt_done;
		MOVE_DONE && pending;
	endsequence

	sequence s_evt_reply;
		RPL_VALID && RPL_STATUS == ST_POS_REACHED && RPL_COMMAND == OP_POS_EVT;
	endsequence

	evt_reply_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		s_evt_done |-> ##[2:4] s_evt_reply)
		else $error("position reached reply missing");

	pos_ack_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(do_arm) |=> (RPL_VALID && RPL_STATUS == ST_OK && RPL_COMMAND == OP_POS_EVT
			&& RPL_VALUE == {24'h000000, $past(CMD_VALUE[7:0])}))
		else $error("position request acknowledge wrong");

	one_shot_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(armed && !arm_every && MOVE_START && !do_arm) |=> !armed)
		else $error("single event stayed armed");

	uf_reply_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(CMD_VALID && !DOWNLOAD_MODE && CMD_OPCODE >= OP_UF_FIRST && CMD_OPCODE <= OP_UF_LAST)
		|=> (RPL_VALID && RPL_STATUS == ST_OK && UF_STROBE))
		else $error("user function not answered");

	no_store_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(CMD_VALID && (mhcc_is_control(CMD_OPCODE) || CMD_OPCODE == OP_POS_EVT)) |-> !do_store)
		else $error("control command stored");

	dl_advance_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(do_store) |=> dl_addr == $past(dl_addr) + 8'h01)
		else $error("download address did not advance");

	factory_quiet_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(do_factory && !evt_flag) |=> (FACTORY_RESTORE && !RPL_VALID))
		else $error("factory restore replied");

	ctx_clear_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(do_clear) |=> (CTX_CLEAR && pc == PC_RESET && seq_state == SEQ_HALTED))
		else $error("program reset incomplete");

	stop_halt_a: assert property (
		@(posedge CLOCK) disable iff (!RST_B)
		(do_halt ##1 !(do_run || do_run_at || do_step)) |-> (seq_state == SEQ_HALTED) [*2])
		else $error("stop did not halt");
endmodule

// [rtl/mhcc_pkg.sv]
package mhcc_pkg;
	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_UF_FIRST = 8'h40;
	localparam logic [7:0] OP_UF_LAST = 8'h47;
	localparam logic [7:0] OP_MOVE = 8'h04;
	localparam logic [7:0] OP_STOP = 8'h80;
	localparam logic [7:0] OP_RUN = 8'h81;
	localparam logic [7:0] OP_STEP = 8'h82;
	localparam logic [7:0] OP_RESET = 8'h83;
	localparam logic [7:0] OP_DL_ENTER = 8'h84;
	localparam logic [7:0] OP_DL_EXIT = 8'h85;
	localparam logic [7:0] OP_READ_MEM = 8'h86;
	localparam logic [7:0] OP_STATUS = 8'h87;
	localparam logic [7:0] OP_VERSION = 8'h88;
	localparam logic [7:0] OP_FACTORY = 8'h89;
	localparam logic [7:0] OP_POS_EVT = 8'h8A;
	localparam logic [7:0] OP_RESTART = 8'hFF;
	// ************************************************************
	// Reply status codes and constants
	// ************************************************************
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_POS_REACHED = 8'h80;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;
	localparam logic [7:0] ST_BUSY = 8'h05;
	localparam logic [31:0] MAGIC_VALUE = 32'h000004D2;
	// Arbitrary version values
	localparam logic [31:0] VERSION_STR = 32'h4D433031;
	localparam logic [31:0] VERSION_BIN = 32'h00010000;
	localparam logic [7:0] MODE_HALTED = 8'h00;
	localparam logic [7:0] MODE_RUNNING = 8'h01;
	localparam logic [7:0] MODE_STEPPING = 8'h02;
	localparam logic [7:0] MODE_DOWNLOAD = 8'h03;
	localparam int PM_AW = 8;
	localparam int PM_DEPTH = 256;
	localparam logic [PM_AW-1:0] PC_RESET = 8'h00;

	typedef enum {SEQ_HALTED, SEQ_RUNNING, SEQ_STEPPING} mhcc_seq_e;

	function automatic logic mhcc_is_control(input logic [7:0] op);
		return ((op >= OP_STOP) && (op <= OP_FACTORY)) || (op == OP_RESTART);
	endfunction
endpackage

// [rtl/mhcc_prog_seq.sv]
`timescale 1ns/10ps
module mhcc_prog_seq import mhcc_pkg::*; (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic halt,
	input wire logic run,
	input wire logic run_at,
	input wire logic [PM_AW-1:0] start_addr,
	input wire logic step,
	input wire logic clear,
	input wire logic download,
	input wire logic grant,
	output logic [PM_AW-1:0] pc,
	output mhcc_seq_e state,
	output logic fetch_req
);
	// ************************************************************
	// Run state and program counter
	// ************************************************************
	// Jumps are left to the executor; this only walks linearly
	assign fetch_req = (state != SEQ_HALTED) && !download;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= SEQ_HALTED;
		end else if (clear || halt) begin
			state <= SEQ_HALTED;
		end else if (run || run_at) begin
			state <= SEQ_RUNNING;
		end else if (step) begin
			state <= SEQ_STEPPING;
		end else if (grant && state == SEQ_STEPPING) begin
			state <= SEQ_HALTED;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pc <= PC_RESET;
		end else if (clear) begin
			pc <= PC_RESET;
		end else if (run_at) begin
			pc <= start_addr;
		end else if (grant) begin
			pc <= pc + 8'h01;
		end
	end

	step_once_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(grant && state == SEQ_STEPPING && !clear && !halt && !run && !run_at && !step)
		|=> state == SEQ_HALTED)
		else $error("step did not halt after one instruction");

	run_at_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		(run_at && !clear) |=> (pc == $past(start_addr) && state == SEQ_RUNNING))
		else $error("run from address not honoured");
endmodule

// [rtl/mhcc_reply_out.sv]
`timescale 1ns/10ps
module mhcc_reply_out import mhcc_pkg::*; (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic imm_valid,
	input wire logic [7:0] imm_status,
	input wire logic [7:0] imm_cmd,
	input wire logic [31:0] imm_value,
	input wire logic evt_req,
	input wire logic [7:0] evt_mask,
	output logic evt_taken,
	output logic rpl_valid,
	output logic [7:0] rpl_status,
	output logic [7:0] rpl_cmd,
	output logic [31:0] rpl_value
);
	// ************************************************************
	// Reply register
	// ************************************************************
	// Immediate replies win; the event reply waits for as long as immediate replies keep coming
	assign evt_taken = evt_req && !imm_valid;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rpl_valid <= 1'b0;
			rpl_status <= 8'h00;
			rpl_cmd <= 8'h00;
			rpl_value <= 32'h00000000;
		end else if (imm_valid) begin
			rpl_valid <= 1'b1;
			rpl_status <= imm_status;
			rpl_cmd <= imm_cmd;
			rpl_value <= imm_value;
		end else if (evt_req) begin
			rpl_valid <= 1'b1;
			rpl_status <= ST_POS_REACHED;
			rpl_cmd <= OP_POS_EVT;
			rpl_value <= {24'h000000, evt_mask};
		end else begin
			rpl_valid <= 1'b0;
		end
	end
endmodule

// [bench/mhcc_host_model.sv]
`timescale 1ns/10ps
module mhcc_host_model import mhcc_pkg::*; (
	input wire logic clock,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] cmd_type,
	output logic [7:0] cmd_bank,
	output logic [31:0] cmd_value
);
	// ************************************************************
	// Frame driver
	// ************************************************************
	initial begin
		cmd_valid = 1'b0;
		cmd_opcode = 8'h00;
		cmd_type = 8'h00;
		cmd_bank = 8'h00;
		cmd_value = 32'h00000000;
	end

	// One frame, one-cycle valid; fields scrambled afterwards so stale data is never reused
	task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
		input logic [31:0] val);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_opcode <= op;
		cmd_type <= typ;
		// Control commands ignore the bank byte, still sent as zero
		cmd_bank <= ((op >= OP_STOP && op <= OP_FACTORY) || op == OP_RESTART) ? 8'h00 : bank;
		// Single motor: only bit 0 of the mask
		cmd_value <= (op == OP_POS_EVT) ? 32'h00000001 : val;
		@(posedge clock);
		cmd_valid <= 1'b0;
		cmd_opcode <= ~op;
		cmd_type <= ~typ;
		cmd_bank <= ~bank;
		cmd_value <= ~val;
	endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
module tb import mhcc_pkg::*; ;
	localparam logic [31:0] UFV = 32'h0BADF00D;
	localparam logic [31:0] ACCV = 32'h12345678;
	localparam logic [31:0] IDXV = 32'h00C0FFEE;
	typedef struct {logic [7:0] op; logic [7:0] typ; logic [31:0] val; logic [7:0] st;
		logic [31:0] exp; bit cv;} mhcc_row_s;
	// ************************************************************
	// Ordinary cases: opcode, type, value, status, reply value
	// ************************************************************
	mhcc_row_s rows[11] = '{
		'{OP_POS_EVT, 8'h01, 32'h01, ST_OK, 32'h01, 1'b1},
		'{OP_POS_EVT, 8'h02, 32'h01, ST_BAD_TYPE, 32'h00, 1'b0},
		'{OP_VERSION, 8'h00, 32'h00, ST_OK, VERSION_STR, 1'b1},
		'{OP_VERSION, 8'h01, 32'h00, ST_OK, VERSION_BIN, 1'b1},
		'{OP_STATUS, 8'h02, 32'h00, ST_OK, ACCV, 1'b1},
		'{OP_STATUS, 8'h03, 32'h00, ST_OK, IDXV, 1'b1},
		'{OP_FACTORY, 8'h00, 32'h05, ST_BAD_VALUE, 32'h00, 1'b0},
		'{OP_RESTART, 8'h00, 32'h05, ST_BAD_VALUE, 32'h00, 1'b0},
		'{OP_DL_EXIT, 8'h00, 32'h00, ST_OK, 32'h00, 1'b0},
		'{OP_STOP, 8'h00, 32'h00, ST_OK, 32'h00, 1'b0},
		'{OP_UF_FIRST, 8'h07, 32'h03, ST_OK, UFV, 1'b1}
	};
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic move_start = 1'b0;
	logic move_done = 1'b0;
	logic exec_ready = 1'b1;
	logic wait_flag = 1'b1;
	logic [31:0] uf_result = UFV;
	logic [31:0] accum = ACCV;
	logic [31:0] index_reg = IDXV;
	logic cmd_valid, rpl_valid, exec_valid, exec_from_prog, uf_strobe, ctx_clear;
	logic factory_restore, cpu_restart, download_mode;
	logic [7:0] cmd_opcode, cmd_type, cmd_bank, rpl_status, rpl_command;
	logic [7:0] exec_opcode, exec_type, exec_bank;
	logic [31:0] cmd_value, rpl_value, exec_value;
	int checked = 0;
	int miscompares = 0;
	int n;

	always #2 clock = ~clock;

	mhcc_host_model host (.clock(clock), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.cmd_type(cmd_type), .cmd_bank(cmd_bank), .cmd_value(cmd_value));

	mhcc_motion_host_control dut (.CLOCK(clock), .RST_B(rst_b), .CMD_VALID(cmd_valid),
		.CMD_OPCODE(cmd_opcode), .CMD_TYPE(cmd_type), .CMD_BANK(cmd_bank),
		.CMD_VALUE(cmd_value), .UF_RESULT(uf_result), .ACCUM(accum), .INDEX_REG(index_reg),
		.WAIT_FLAG(wait_flag), .MOVE_START(move_start), .MOVE_DONE(move_done),
		.EXEC_READY(exec_ready), .RPL_VALID(rpl_valid), .RPL_STATUS(rpl_status),
		.RPL_COMMAND(rpl_command), .RPL_VALUE(rpl_value), .EXEC_VALID(exec_valid),
		.EXEC_OPCODE(exec_opcode), .EXEC_TYPE(exec_type), .EXEC_BANK(exec_bank),
		.EXEC_VALUE(exec_value), .EXEC_FROM_PROG(exec_from_prog), .UF_STROBE(uf_strobe),
		.CTX_CLEAR(ctx_clear), .FACTORY_RESTORE(factory_restore), .CPU_RESTART(cpu_restart),
		.DOWNLOAD_MODE(download_mode));

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Reply is due at the same edge that takes the frame
	task automatic reply(input logic [7:0] st, input logic [7:0] cmd, input logic [31:0] val,
		input bit cv);
		#1;
		chk(32'(rpl_valid), 32'h1);
		chk(32'(rpl_status), 32'(st));
		chk(32'(rpl_command), 32'(cmd));
		if (cv)
			chk(rpl_value, val);
	endtask

	// Move pulses; a reached reply must come within a fixed window or not at all
	task automatic move(input bit expect_rpl);
		bit seen;
		seen = 1'b0;
		@(posedge clock);
		move_start <= 1'b1;
		@(posedge clock);
		move_start <= 1'b0;
		repeat (3) @(posedge clock);
		move_done <= 1'b1;
		@(posedge clock);
		move_done <= 1'b0;
		repeat (5) begin
			@(posedge clock);
			#1;
			if (rpl_valid === 1'b1 && !seen) begin
				seen = 1'b1;
				chk(32'(rpl_status), 32'(ST_POS_REACHED));
				chk(32'(rpl_command), 32'(OP_POS_EVT));
				chk(rpl_value, 32'h00000001);
			end
		end
		chk(32'(seen), 32'(expect_rpl));
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (15) @(posedge clock);
		#1;
		chk({rpl_valid, exec_valid, download_mode, ctx_clear, uf_strobe}, 32'h0);
		@(posedge clock);
		rst_b <= 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			host.send(rows[i].op, rows[i].typ, 8'h00, rows[i].val);
			reply(rows[i].st, rows[i].op, rows[i].exp, rows[i].cv);
		end
		for (int i = 64; i <= 71; i++) begin
			host.send(8'(i), 8'h00, 8'h00, 32'h00);
			reply(ST_OK, 8'(i), UFV, 1'b1);
			chk(32'(uf_strobe), 32'h1);
		end
		$display("test table done");
		// Single-shot arming, then repeated arming
		host.send(OP_POS_EVT, 8'h00, 8'h00, 32'h01);
		reply(ST_OK, OP_POS_EVT, 32'h01, 1'b1);
		move(1'b1);
		move(1'b0);
		host.send(OP_POS_EVT, 8'h01, 8'h00, 32'h01);
		reply(ST_OK, OP_POS_EVT, 32'h01, 1'b1);
		move(1'b1);
		move(1'b1);
		$display("test position event done");
		host.send(OP_DL_ENTER, 8'h00, 8'h00, 32'h0A);
		reply(ST_OK, OP_DL_ENTER, 32'h0, 1'b0);
		chk(32'(download_mode), 32'h1);
		host.send(8'h05, 8'h02, 8'h03, 32'h77);
		reply(ST_OK, 8'h05, 32'h0, 1'b1);
		chk(32'(exec_valid), 32'h0);
		host.send(OP_POS_EVT, 8'h01, 8'h00, 32'h01);
		reply(ST_BAD_CMD, OP_POS_EVT, 32'h0, 1'b0);
		host.send(8'h06, 8'h01, 8'h03, 32'h55);
		reply(ST_OK, 8'h06, 32'h0, 1'b1);
		host.send(OP_STATUS, 8'h00, 8'h00, 32'h00);
		reply(ST_OK, OP_STATUS, {MODE_DOWNLOAD, 8'h01, 8'h00, 8'h0C}, 1'b1);
		host.send(OP_DL_EXIT, 8'h00, 8'h00, 32'h00);
		reply(ST_OK, OP_DL_EXIT, 32'h0, 1'b0);
		chk(32'(download_mode), 32'h0);
		host.send(OP_READ_MEM, 8'h00, 8'h00, 32'h0A);
		reply(8'h05, 8'h02, 32'h77, 1'b1);
		host.send(OP_READ_MEM, 8'h00, 8'h00, 32'h0B);
		reply(8'h06, 8'h01, 32'h55, 1'b1);
		$display("test download done");
		host.send(OP_RUN, 8'h01, 8'h00, 32'h0A);
		reply(ST_OK, OP_RUN, 32'h0, 1'b0);
		for (n = 0; n < 4 && exec_valid !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		if (n >= 4) begin
			miscompares++;
			end_of_test();
		end
		chk({exec_opcode, exec_type, 15'h0, exec_from_prog}, 32'h05020001);
		chk(exec_value, 32'h77);
		@(posedge clock);
		#1;
		chk(32'(exec_opcode), 32'h06);
		host.send(OP_STATUS, 8'h01, 8'h00, 32'h00);
		reply(ST_OK, OP_STATUS, {MODE_RUNNING, 8'h01, 8'h00, 8'h0D}, 1'b1);
		host.send(OP_STOP, 8'h00, 8'h00, 32'h00);
		reply(ST_OK, OP_STOP, 32'h0, 1'b0);
		repeat (2) @(posedge clock);
		n = 0;
		repeat (4) begin
			@(posedge clock);
			#1;
			n += int'(exec_valid === 1'b1);
		end
		chk(32'(n), 32'h0);
		$display("test run stop done");
		host.send(OP_RESET, 8'h00, 8'h00, 32'h00);
		reply(ST_OK, OP_RESET, 32'h0, 1'b0);
		chk(32'(ctx_clear), 32'h1);
		host.send(OP_STATUS, 8'h01, 8'h00, 32'h00);
		reply(ST_OK, OP_STATUS, {MODE_HALTED, 8'h01, 8'h00, 8'h00}, 1'b1);
		host.send(OP_STEP, 8'h00, 8'h00, 32'h00);
		reply(ST_OK, OP_STEP, 32'h0, 1'b0);
		n = int'(exec_valid === 1'b1);
		repeat (6) begin
			@(posedge clock);
			#1;
			n += int'(exec_valid === 1'b1);
		end
		chk(32'(n), 32'h1);
		host.send(OP_STATUS, 8'h01, 8'h00, 32'h00);
		reply(ST_OK, OP_STATUS, {MODE_HALTED, 8'h01, 8'h00, 8'h01}, 1'b1);
		$display("test reset step done");
		// Stalled executor: second forward is refused, control still served
		@(posedge clock);
		exec_ready <= 1'b0;
		host.send(8'h05, 8'h02, 8'h03, 32'h77);
		@(posedge clock);
		#1;
		chk(32'(rpl_valid), 32'h0);
		chk({exec_valid, exec_from_prog, exec_bank}, 32'h203);
		host.send(8'h06, 8'h00, 8'h03, 32'h00);
		reply(ST_BUSY, 8'h06, 32'h0, 1'b0);
		chk(32'(exec_opcode), 32'h05);
		host.send(OP_VERSION, 8'h01, 8'h00, 32'h00);
		reply(ST_OK, OP_VERSION, VERSION_BIN, 1'b1);
		chk(32'(exec_opcode), 32'h05);
		@(posedge clock);
		exec_ready <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk(32'(exec_valid), 32'h0);
		$display("test busy done");
		// Host does not wait for a reply here
		host.send(OP_FACTORY, 8'h00, 8'h00, MAGIC_VALUE);
		#1;
		chk({factory_restore, rpl_valid}, 32'h2);
		@(posedge clock);
		#1;
		chk(32'(rpl_valid), 32'h0);
		host.send(OP_RESTART, 8'h00, 8'h00, MAGIC_VALUE);
		reply(ST_OK, OP_RESTART, 32'h0, 1'b0);
		chk(32'(cpu_restart), 32'h1);
		$display("test restore restart done");
		end_of_test();
	end
endmodule
